/* File: flash_seq_defs.svh */
/*
  Constants for the serial flash instruction sequencer: instruction codes,
  status bit positions, reset values and self-timed delays.
  Assumes it is included by its bare name before any module that uses it.
*/
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// Core clock rate in MHz
`define CORE_CLK_MHZ 200

// Instruction codes
`define OP_WRITE_ENABLE 8'h06
`define OP_STATUS_READ 8'h05
`define OP_ARRAY_ERASE 8'hc7
`define OP_SLEEP_ENTRY 8'hb9
`define OP_WAKE_SIG 8'hab
`define OP_PARAM_READ 8'h53
`define OP_PARAM_FAST 8'h5b

// Status byte field positions
`define ST_WIP_BIT 0
`define ST_WEL_BIT 1
`define ST_BP_LSB 2

// Reset value of every parameter page byte
`define PARAM_RESET_BYTE 8'hff

// Bit counts of the serial fields, minus one
`define OPCODE_LAST 5'd7
`define ADDR_LAST 5'd23
`define FAST_DUMMY_LAST 5'd7
`define SIG_DUMMY_LAST 5'd23

// Self-timed delays in their own units
`define ARRAY_ERASE_TIME_US 100000
`define SLEEP_ENTRY_DELAY_NS 3000
`define WAKE_DELAY_NS 3000

`endif

/* File: flash_seq_pkg.sv */
/*
  Types for the serial flash instruction sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_seq_pkg;

  // Phase of the serial frame
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_OUT,
    PH_IGNORE
  } frame_phase_t;

  // Self-timed operation in progress
  typedef enum logic [1:0] {
    TM_NONE,
    TM_ERASE,
    TM_SLEEP,
    TM_WAKE
  } timer_mode_t;

endpackage

/* File: serial_flash_seq.sv */
/*
  Serial flash instruction sequencer: whole array erase, deep sleep entry,
  wake with signature readout, status readout and parameter page reads.
  Assumes the serial link pins arrive asynchronously to core_clk_in, that
  the serial clock runs well below a quarter of the core clock, and that
  the array, the block protect bits and other write cycles live elsewhere.
*/
// What this block does
// R1 - Whole array erase sets array to ones
// R2 - Erase needs write enable latch set
// R3 - Host sends erase opcode only, select low
// R4 - Select rise starts timed erase cycle
// R5 - Status readable, progress bit during erase
// R6 - Write enable latch cleared before finish
// R7 - Erase only when all protect bits zero
// R8 - Select rise after opcode starts sleep
// R9 - Wait sleep entry delay, then sleep
// R10 - Asleep: ignore all but wake command
// R11 - Sleep entry rejected during busy cycle
// R12 - Wake: three dummy bytes, then signature
// R13 - Signature repeats while select low
// R14 - Wake not decoded during busy cycle
// R15 - Wake while awake returns immediately
// R16 - Wake from sleep delayed by wake delay
// R17 - Early select rise still wakes device
// R18 - Page read: opcode then 24 address bits
// R19 - Only low eight address bits used
// R20 - MSB first, address increments and wraps
// R21 - Read ends on select high, busy rejects
// R22 - Fast read adds one dummy byte
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Output byte FIFO with flush
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage words
  logic [AW-1:0] wr_ptr_reg; // Next slot to fill
  logic [AW-1:0] rd_ptr_reg; // Next slot to drain
  logic [AW:0] count_reg; // Words held
  logic push; // Word taken in
  logic pop; // Word handed out

  assign in_ready_out = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Storage write, no reset needed on data
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Sequencer top
module serial_flash_seq #(
  parameter int ERASE_CYCLES = `ARRAY_ERASE_TIME_US * `CORE_CLK_MHZ,
  parameter int SLEEP_CYCLES =
    (`SLEEP_ENTRY_DELAY_NS * `CORE_CLK_MHZ + 999) / 1000,
  parameter int WAKE_CYCLES = (`WAKE_DELAY_NS * `CORE_CLK_MHZ + 999) / 1000,
  parameter logic [7:0] SIGNATURE = 8'h5a, // Arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Serial link pins
  input wire logic chip_select_n_in,
  input wire logic sck_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_oe_out,
  // Protection and other write machines
  input wire logic [2:0] block_protect_in,
  input wire logic other_cycle_busy_in,
  // Parameter page load port
  input wire logic param_load_en_in,
  input wire logic [7:0] param_load_addr_in,
  input wire logic [7:0] param_load_data_in,
  // Status and array control
  output logic write_enable_latch_out,
  output logic write_in_progress_flag_out,
  output logic deep_sleep_out,
  output logic whole_array_erase_out
);
  import flash_seq_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg; // Select stages
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg; // Clock stages
  logic si_s1_reg, si_s2_reg; // Data stages

  // Two flops per pin, third stage only for edge finding
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= chip_select_n_in;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      sck_s1_reg <= sck_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      si_s1_reg <= serial_in;
      si_s2_reg <= si_s1_reg;
    end
  end

  wire sck_rise = sck_s2_reg & ~sck_s3_reg & ~cs_s2_reg; // Data latch edge
  wire sck_fall = ~sck_s2_reg & sck_s3_reg & ~cs_s2_reg; // Data shift edge
  wire cs_rise = cs_s2_reg & ~cs_s3_reg; // End of frame

  //////////////////////////////////////////////////////////////////////////
  // State declarations
  frame_phase_t phase_reg; // Frame phase
  logic [4:0] cnt_reg; // Bit count inside a field
  logic [3:0] total_reg; // Frame bits, saturating
  logic [7:0] opcode_reg; // Captured instruction
  logic [7:0] in_shift_reg; // Opcode shifter
  logic [7:0] addr_reg; // Page byte location
  timer_mode_t tmode_reg; // Self-timed operation
  logic [31:0] timer_reg; // Cycles left
  logic wel_reg; // Write enable latch
  logic sleep_reg; // Deep sleep state
  logic erase_pulse_reg; // Array fill pulse
  logic [7:0] out_shift_reg; // Serial output byte
  logic [2:0] out_bit_reg; // Bits left in byte
  logic so_reg; // Serial output bit
  logic oe_reg; // Output driven
  logic [7:0] param_mem_reg [256]; // Parameter page

  //////////////////////////////////////////////////////////////////////////
  // Decoding
  wire busy = (tmode_reg == TM_ERASE) | other_cycle_busy_in;
  wire asleep = sleep_reg | (tmode_reg == TM_SLEEP) | (tmode_reg == TM_WAKE);
  wire [7:0] op_next = {in_shift_reg[6:0], si_s2_reg};
  wire exact8 = (total_reg == 4'd8); // Opcode only, no extra bits
  wire got_op = (total_reg >= 4'd8);
  wire op_is_read = (op_next == `OP_PARAM_READ) | (op_next == `OP_PARAM_FAST);
  wire [4:0] dummy_last =
    (opcode_reg == `OP_WAKE_SIG) ? `SIG_DUMMY_LAST : `FAST_DUMMY_LAST;
  wire [7:0] status_byte =
    {3'h0, block_protect_in, wel_reg, busy};

  // Phase after the opcode byte
  function automatic frame_phase_t op_phase(input logic [7:0] op,
                                            input logic slp,
                                            input logic bsy);
    frame_phase_t ph;
    ph = PH_IGNORE;
    if ((op == `OP_PARAM_READ || op == `OP_PARAM_FAST) && !slp && !bsy) begin
      ph = PH_ADDR; // R18 R21
    end else if (op == `OP_WAKE_SIG && !bsy) begin
      ph = PH_DUMMY; // R10 R12 R14
    end else if (op == `OP_STATUS_READ && !slp) begin
      ph = PH_OUT; // R5
    end
    return ph;
  endfunction

  // Frame end actions
  wire write_enable_cmd_ok = cs_rise & exact8 & (opcode_reg == `OP_WRITE_ENABLE) &
    ~asleep & ~busy; // R2 R10
  wire erase_ok = cs_rise & exact8 & (opcode_reg == `OP_ARRAY_ERASE) &
    wel_reg & (block_protect_in == 3'h0) & ~asleep & ~busy; // R2 R3 R7 R10
  wire sleep_ok = cs_rise & exact8 & (opcode_reg == `OP_SLEEP_ENTRY) &
    ~asleep & ~busy; // R8 R11
  wire wake_ok = cs_rise & got_op & (opcode_reg == `OP_WAKE_SIG) &
    ~busy; // R14 R17

  //////////////////////////////////////////////////////////////////////////
  // Output byte path
  logic fifo_in_ready; // Room in FIFO
  logic fifo_out_valid; // Byte waiting
  logic [7:0] fifo_out_data; // Head byte
  wire src_param = (opcode_reg == `OP_PARAM_READ) |
    (opcode_reg == `OP_PARAM_FAST);
  wire [7:0] fetch_data = src_param ? param_mem_reg[addr_reg] :
    (opcode_reg == `OP_WAKE_SIG) ? SIGNATURE : status_byte; // R13
  wire fetch_valid = (phase_reg == PH_OUT) & ~cs_s2_reg & ~sck_rise;
  wire fetch_fire = fetch_valid & fifo_in_ready;
  wire byte_start = sck_fall & (phase_reg == PH_OUT) & (out_bit_reg == 3'd0);
  wire pop = byte_start & fifo_out_valid;

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) out_fifo (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .flush_in(cs_s2_reg),
    .in_valid_in(fetch_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fetch_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Parameter page storage, one generate slice per byte
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_page
      always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
          param_mem_reg[gi] <= `PARAM_RESET_BYTE;
        end else if (param_load_en_in && param_load_addr_in == 8'(gi)) begin
          param_mem_reg[gi] <= param_load_data_in;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Frame sequencer: opcode, address and dummy fields
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_reg <= PH_OPCODE;
      cnt_reg <= 5'd0;
      total_reg <= 4'd0;
      opcode_reg <= 8'h00;
      in_shift_reg <= 8'h00;
      addr_reg <= 8'h00;
    end else if (cs_s2_reg) begin
      // Deselected: frame over, reads end here
      phase_reg <= PH_OPCODE; // R21
      cnt_reg <= 5'd0;
      total_reg <= 4'd0;
    end else if (sck_rise) begin
      total_reg <= (total_reg == 4'hf) ? total_reg : total_reg + 4'd1;
      in_shift_reg <= op_next;
      case (phase_reg)
        PH_OPCODE: begin
          if (cnt_reg == `OPCODE_LAST) begin
            opcode_reg <= op_next;
            phase_reg <= op_phase(op_next, asleep, busy);
            cnt_reg <= 5'd0;
          end else begin
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        PH_ADDR: begin
          // Upper sixteen bits fall out of the byte shifter
          addr_reg <= {addr_reg[6:0], si_s2_reg}; // R19
          if (cnt_reg == `ADDR_LAST) begin
            phase_reg <= (opcode_reg == `OP_PARAM_FAST) ? PH_DUMMY :
              PH_OUT; // R22
            cnt_reg <= 5'd0;
          end else begin
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        PH_DUMMY: begin
          if (cnt_reg == dummy_last) begin
            phase_reg <= PH_OUT; // R12 R22
            cnt_reg <= 5'd0;
          end else begin
            cnt_reg <= cnt_reg + 5'd1;
          end
        end
        default: begin
          phase_reg <= phase_reg;
        end
      endcase
    end else if (fetch_fire && src_param) begin
      // Next page byte, wraps at the page end
      addr_reg <= addr_reg + 8'd1; // R20
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial output shifter, MSB first on falling clock
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_shift_reg <= 8'h00;
      out_bit_reg <= 3'd0;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (cs_s2_reg) begin
      out_bit_reg <= 3'd0;
      oe_reg <= 1'b0;
    end else if (byte_start) begin
      // Load next byte; an empty FIFO sends ones
      so_reg <= fifo_out_valid ? fifo_out_data[7] : 1'b1; // R20
      out_shift_reg <= fifo_out_valid ? {fifo_out_data[6:0], 1'b0} : 8'hfe;
      out_bit_reg <= 3'd7;
      oe_reg <= 1'b1;
    end else if (sck_fall && phase_reg == PH_OUT) begin
      so_reg <= out_shift_reg[7];
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      out_bit_reg <= out_bit_reg - 3'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write enable latch, timers, sleep state
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wel_reg <= 1'b0;
      tmode_reg <= TM_NONE;
      timer_reg <= 32'h0;
      sleep_reg <= 1'b0;
      erase_pulse_reg <= 1'b0;
    end else begin
      erase_pulse_reg <= 1'b0;
      if (write_enable_cmd_ok) begin
        wel_reg <= 1'b1; // R2
      end
      if (erase_ok) begin
        // Latch drops as the cycle starts
        wel_reg <= 1'b0; // R6
        tmode_reg <= TM_ERASE; // R4
        timer_reg <= 32'(ERASE_CYCLES - 1);
      end else if (sleep_ok) begin
        tmode_reg <= TM_SLEEP; // R8 R9
        timer_reg <= 32'(SLEEP_CYCLES - 1);
      end else if (wake_ok && sleep_reg) begin
        tmode_reg <= TM_WAKE; // R16
        timer_reg <= 32'(WAKE_CYCLES - 1);
      end else if (wake_ok && tmode_reg == TM_SLEEP) begin
        // Wake during entry delay cancels it at once
        tmode_reg <= TM_NONE; // R15
      end else if (tmode_reg != TM_NONE) begin
        if (timer_reg == 32'h0) begin
          case (tmode_reg)
            TM_ERASE: erase_pulse_reg <= 1'b1; // R1
            TM_SLEEP: sleep_reg <= 1'b1; // R9
            TM_WAKE: sleep_reg <= 1'b0; // R16
            default: sleep_reg <= sleep_reg;
          endcase
          tmode_reg <= TM_NONE;
        end else begin
          timer_reg <= timer_reg - 32'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      write_in_progress_flag_out <= 1'b0;
      deep_sleep_out <= 1'b0;
    end else begin
      write_in_progress_flag_out <= (tmode_reg == TM_ERASE); // R5
      deep_sleep_out <= asleep;
    end
  end

  assign serial_out = so_reg;
  assign serial_oe_out = oe_reg;
  assign write_enable_latch_out = wel_reg;
  assign whole_array_erase_out = erase_pulse_reg;
endmodule

/* File: serial_flash_seq_asserts.sv */
/*
  Port checker for the serial flash sequencer: erase, latch, sleep, output.
  Assumes it is bound to serial_flash_seq and shares its core clock.
*/
`timescale 1ns/1ps
module serial_flash_seq_asserts #(
  parameter int ERASE_CYCLES = 50
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Watched pins
  input wire logic chip_select_n_in,
  input wire logic serial_oe_out,
  input wire logic [2:0] block_protect_in,
  input wire logic write_enable_latch_out,
  input wire logic write_in_progress_flag_out,
  input wire logic deep_sleep_out,
  input wire logic whole_array_erase_out
);
  int busy_cnt; // Cycles spent in the current erase

  ////////////////////////////////////////////////////////////////////////
  // Erase length counter
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_cnt <= 0;
    end else if (write_in_progress_flag_out) begin
      busy_cnt <= busy_cnt + 1;
    end else begin
      busy_cnt <= 0;
    end
  end

  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////////////////
  // Properties
  property p_pulse_width;
    whole_array_erase_out |=> !whole_array_erase_out;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("erase pulse longer than one cycle");
  property p_pulse_busy;
    whole_array_erase_out |-> $past(write_in_progress_flag_out);
  endproperty
  a_pulse_busy: assert property (p_pulse_busy)
    else $error("erase pulse without erase cycle");
  property p_erase_len;
    $fell(write_in_progress_flag_out) |->
      busy_cnt >= ERASE_CYCLES - 4 && busy_cnt <= ERASE_CYCLES + 4;
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase cycle length wrong");
  property p_end_clear;
    $rose(whole_array_erase_out) |-> ##[0:2] !write_in_progress_flag_out;
  endproperty
  a_end_clear: assert property (p_end_clear)
    else $error("progress flag stuck after erase");
  property p_wel_needed;
    $rose(write_in_progress_flag_out) |->
      $past(write_enable_latch_out, 1) || $past(write_enable_latch_out, 2);
  endproperty
  a_wel_needed: assert property (p_wel_needed)
    else $error("erase started without latch");
  property p_wel_clear;
    $rose(write_in_progress_flag_out) |-> ##[0:2] !write_enable_latch_out;
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("latch not cleared at erase");
  property p_protect;
    $rose(write_in_progress_flag_out) |-> block_protect_in == 3'h0;
  endproperty
  a_protect: assert property (p_protect)
    else $error("erase while protected");
  property p_sleep_busy;
    $rose(deep_sleep_out) |-> !write_in_progress_flag_out && chip_select_n_in;
  endproperty
  a_sleep_busy: assert property (p_sleep_busy)
    else $error("sleep entered while busy or selected");
  property p_sleep_no_erase;
    deep_sleep_out |-> !$rose(write_in_progress_flag_out);
  endproperty
  a_sleep_no_erase: assert property (p_sleep_no_erase)
    else $error("erase started while asleep");
  property p_oe_release;
    $rose(chip_select_n_in) |-> ##[1:8] !serial_oe_out;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("output kept driven after deselect");
endmodule

bind serial_flash_seq serial_flash_seq_asserts #(
  .ERASE_CYCLES(ERASE_CYCLES)
) serial_flash_seq_asserts_inst (
  .core_clk_in(core_clk_in),
  .reset_in(reset_in),
  .chip_select_n_in(chip_select_n_in),
  .serial_oe_out(serial_oe_out),
  .block_protect_in(block_protect_in),
  .write_enable_latch_out(write_enable_latch_out),
  .write_in_progress_flag_out(write_in_progress_flag_out),
  .deep_sleep_out(deep_sleep_out),
  .whole_array_erase_out(whole_array_erase_out)
);

/* File: spi_host_model.sv */
/*
  Serial host model: mode 0 frames with a 160 ns link clock.
  Assumes the bench fills tx before a frame and reads rx after it.
*/
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire logic core_clk_in,
  // Link pins
  output logic chip_select_n_out,
  output logic sck_out,
  output logic serial_data_out,
  input wire logic serial_in,
  input wire logic serial_oe_in
);
  logic [7:0] tx [0:15]; // Bytes to send
  logic [7:0] rx [0:15]; // Bytes seen
  logic oe_seen; // Device drove the line this frame

  initial begin
    chip_select_n_out = 1'b1;
    sck_out = 1'b0;
    serial_data_out = 1'b0;
    oe_seen = 1'b0;
  end

  // Wait n core cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // One frame of nb bytes, MSB first, clock idle low
  task automatic frame(input int nb);
    oe_seen = 1'b0;
    chip_select_n_out = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      serial_data_out = tx[i / 8][7 - i % 8];
      tick(16);
      sck_out = 1'b1;
      rx[i / 8][7 - i % 8] = serial_in;
      oe_seen = oe_seen | serial_oe_in;
      tick(16);
      sck_out = 1'b0;
    end
    tick(16);
    chip_select_n_out = 1'b1;
    serial_data_out = ~serial_data_out;
    tick(8);
  endtask
endmodule

/* File: serial_flash_seq_tb_top.sv */
/*
  Self-checking bench for the serial flash sequencer.
  Assumes the host model drives the link and short self-timed counts.
*/
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module serial_flash_seq_tb_top;
  localparam int ERASE_N = 4000;
  localparam logic [7:0] SIG = 8'h3c; // Arbitrary value
  logic core_clk_in, reset_in, cs_n, sck, sdi, sdo, oe;
  logic [2:0] bp;
  logic other_busy, ld_en, write_enable_latch, write_in_progress_flag, sleep, erase_pulse, got;
  logic [7:0] ld_addr, ld_data;
  logic [7:0] page [0:255]; // Expected page contents
  logic [31:0] lfsr_state;
  int n_errors, num_checks;

  serial_flash_seq #(.ERASE_CYCLES(ERASE_N), .SLEEP_CYCLES(10),
    .WAKE_CYCLES(10), .SIGNATURE(SIG), .FIFO_DEPTH(8)) serial_flash_seq_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in),
    .chip_select_n_in(cs_n), .sck_in(sck), .serial_in(sdi),
    .serial_out(sdo), .serial_oe_out(oe), .block_protect_in(bp),
    .other_cycle_busy_in(other_busy), .param_load_en_in(ld_en),
    .param_load_addr_in(ld_addr), .param_load_data_in(ld_data),
    .write_enable_latch_out(write_enable_latch), .write_in_progress_flag_out(write_in_progress_flag),
    .deep_sleep_out(sleep), .whole_array_erase_out(erase_pulse));
  spi_host_model spi_host_model_inst (.core_clk_in(core_clk_in),
    .chip_select_n_out(cs_n), .sck_out(sck), .serial_data_out(sdi),
    .serial_in(sdo), .serial_oe_in(oe));

  // Next random value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected status byte
  function automatic logic [7:0] stat_exp(input logic [2:0] b,
                                          input logic l, input logic y);
    return {3'h0, b, l, y};
  endfunction
  // Byte comparison
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got_v);
    num_checks++;
    if (got_v !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got_v);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // Short command frame
  task automatic cmd(input logic [7:0] op, input int nb);
    spi_host_model_inst.tx[0] = op;
    spi_host_model_inst.frame(nb);
    cyc(8);
  endtask
  // Page read, normal or fast, checking nr bytes
  task automatic page_rd(input logic [7:0] op, input logic [23:0] a,
                         input int nr);
    int hd;
    hd = (op == `OP_PARAM_FAST) ? 5 : 4;
    lfsr_state = lfsr(lfsr_state);
    spi_host_model_inst.tx[1] = a[23:16];
    spi_host_model_inst.tx[2] = a[15:8];
    spi_host_model_inst.tx[3] = a[7:0];
    spi_host_model_inst.tx[4] = lfsr_state[7:0];
    cmd(op, hd + nr);
    for (int i = 0; i < nr; i++) begin
      chk("page byte", page[8'(a[7:0] + i)],
          spi_host_model_inst.rx[hd + i]);
    end
    chk("read oe", 8'h01, {7'h0, spi_host_model_inst.oe_seen});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Core clock, 200 MHz
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_in = 1'b1;
    bp = 3'h0;
    other_busy = 1'b0;
    ld_en = 1'b0;
    ld_addr = 8'h00;
    ld_data = 8'h00;
    lfsr_state = 32'h9e15b04e;
    n_errors = 0;
    num_checks = 0;
    for (int i = 0; i < 256; i++) page[i] = 8'hff;
    cyc(20);
    reset_in = 1'b0;
    cyc(4);
    chk("reset outs", 8'h00, {4'h0, oe, write_enable_latch, write_in_progress_flag, sleep});
    page_rd(`OP_PARAM_READ, 24'h000010, 2);
    // Fill the page with random bytes
    for (int i = 0; i < 256; i++) begin
      lfsr_state = lfsr(lfsr_state);
      ld_en = 1'b1;
      ld_addr = i[7:0];
      ld_data = lfsr_state[7:0];
      page[i] = lfsr_state[7:0];
      cyc(1);
    end
    ld_en = 1'b0;
    page_rd(`OP_PARAM_READ, 24'habcdfe, 4);
    page_rd(`OP_PARAM_FAST, 24'h1234ff, 3);
    for (int k = 0; k < 4; k++) begin
      lfsr_state = lfsr(lfsr_state);
      page_rd(k[0] ? `OP_PARAM_FAST : `OP_PARAM_READ, lfsr_state[23:0], 2);
    end
    // Signature while awake, repeated
    cmd(`OP_WAKE_SIG, 6);
    chk("sig", SIG, spi_host_model_inst.rx[4]);
    chk("sig again", SIG, spi_host_model_inst.rx[5]);
    chk("awake", 8'h00, {7'h0, sleep});
    // Another machine busy
    other_busy = 1'b1;
    cmd(`OP_PARAM_READ, 6);
    chk("busy read oe", 8'h00, {7'h0, spi_host_model_inst.oe_seen});
    cmd(`OP_STATUS_READ, 2);
    chk("status", stat_exp(3'h0, 1'b0, 1'b1),
        spi_host_model_inst.rx[1]);
    other_busy = 1'b0;
    // Erase refused without latch, then while protected
    cmd(`OP_ARRAY_ERASE, 1);
    chk("no latch", 8'h00, {6'h0, write_enable_latch, write_in_progress_flag});
    cmd(`OP_WRITE_ENABLE, 1);
    bp = 3'h4;
    cmd(`OP_ARRAY_ERASE, 1);
    chk("protected", 8'h02, {6'h0, write_enable_latch, write_in_progress_flag});
    bp = 3'h0;
    cmd(`OP_ARRAY_ERASE, 1);
    chk("erasing", 8'h01, {6'h0, write_enable_latch, write_in_progress_flag});
    cmd(`OP_STATUS_READ, 2);
    chk("status", stat_exp(3'h0, 1'b0, 1'b1),
        spi_host_model_inst.rx[1]);
    cmd(`OP_SLEEP_ENTRY, 1);
    chk("busy sleep", 8'h00, {7'h0, sleep});
    cmd(`OP_WAKE_SIG, 5);
    chk("busy wake oe", 8'h00, {7'h0, spi_host_model_inst.oe_seen});
    cmd(`OP_PARAM_READ, 5);
    chk("busy read oe", 8'h00, {7'h0, spi_host_model_inst.oe_seen});
    got = 1'b0;
    for (int i = 0; i < ERASE_N + 2000 && !got; i++) begin
      cyc(1);
      if (erase_pulse === 1'b1) got = 1'b1;
    end
    chk("erase end", 8'h01, {7'h0, got});
    if (!got) give_verdict();
    cyc(4);
    chk("erase done", 8'h00, {6'h0, write_enable_latch, write_in_progress_flag});
    // Sleep, ignored commands, early wake
    cmd(`OP_SLEEP_ENTRY, 1);
    cyc(20);
    chk("asleep", 8'h01, {7'h0, sleep});
    cmd(`OP_WRITE_ENABLE, 1);
    chk("sleep latch", 8'h00, {7'h0, write_enable_latch});
    cmd(`OP_PARAM_READ, 6);
    chk("sleep oe", 8'h00, {7'h0, spi_host_model_inst.oe_seen});
    cmd(`OP_WAKE_SIG, 1);
    cyc(30);
    chk("woken", 8'h00, {7'h0, sleep});
    page_rd(`OP_PARAM_READ, 24'h000080, 2);
    give_verdict();
  end
endmodule
